// >>> design/timer_option_pkg.sv
// Package with offsets, field positions, reset values and helpers for the timer option block
package timer_option_pkg;

   // ------------------------------------------------------------
   // Register map (index printed per register, byte address = 4 * index)
   // ------------------------------------------------------------
   localparam logic [11:0] OPTION_IDX = 12'h081;
   localparam logic [11:0] OPTION_ADDR = 12'(OPTION_IDX << 2);
   localparam logic [11:0] STATUS_IDX = 12'h082;
   localparam logic [11:0] STATUS_ADDR = 12'(STATUS_IDX << 2);

   // ------------------------------------------------------------
   // Option register fields and reset value
   // ------------------------------------------------------------
   localparam int PULLUP_DIS_BIT = 7;
   localparam int IRQ_EDGE_BIT = 6;
   localparam int CLK_SRC_BIT = 5;
   localparam int SRC_EDGE_BIT = 4;
   localparam int ASSIGN_BIT = 3;
   localparam int RATE_MSB = 2;
   localparam int RATE_LSB = 0;
   localparam logic [7:0] OPTION_RESET = 8'hff;

   // ------------------------------------------------------------
   // Input synchroniser and prescaler reset values
   // ------------------------------------------------------------
   localparam logic [2:0] SYNC_RESET = 3'h0;
   localparam logic [7:0] COUNT_RESET = 8'h00;

   // Low-bit mask of a divide-by-2^exp counter; exp 8 gives all ones
   function automatic logic [7:0] rate_mask(input logic [3:0] exp);
      logic [8:0] full;
      full = (9'h001 << exp) - 9'h001;
      return full[7:0];
   endfunction : rate_mask

endpackage : timer_option_pkg

// >>> design/prescale_divider.sv
// Shared power-of-two prescaler counter with a registered tick output
`timescale 1ns/1ps
`default_nettype none

module prescale_divider (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic event_in,
   input wire logic clear,
   input wire logic [3:0] rate_exp,
   output logic tick_q,
   output logic [7:0] count_q
);

   logic [7:0] mask;

   // ------------------------------------------------------------
   // Divider
   // ------------------------------------------------------------

   assign mask = timer_option_pkg::rate_mask(rate_exp);

   // Tick on the event that completes 2^exp events; exp 0 passes every event
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= timer_option_pkg::COUNT_RESET;
         tick_q <= 1'b0;
      end else if (clear) begin
         // Clearing drops a half-finished count so a new ratio starts clean
         count_q <= timer_option_pkg::COUNT_RESET;
         tick_q <= 1'b0;
      end else begin
         tick_q <= event_in && ((count_q & mask) == mask);
         if (event_in) begin
            count_q <= count_q + 8'h01;
         end
      end
   end

endmodule : prescale_divider

`default_nettype wire

// >>> design/timer_option_config.sv
// Timer clock source, edge and prescaler configuration register behind an Avalon-MM slave
//
// What this block does
// - Counting from the pin: falling edge when edge select is 1, rising when 0.
// - One prescaler: assign bit 0 divides the timer input, 1 moves it to watchdog.
// - Timer-side prescale divides by 2 to the power of rate field plus one.
// - Watchdog-side prescale divides by 2 to the power of rate field.
// - With prescaler on watchdog, timer counts every source event undivided.
`timescale 1ns/1ps
`default_nettype none

module timer_option_config (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic timer_count_pin,
   input wire logic instr_cycle_tick,
   input wire logic watchdog_osc_tick,
   output logic timer_increment,
   output logic watchdog_increment,
   output logic port_b_a_pullup_disable,
   output logic ext_irq_edge_select
);

   logic [7:0] option_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic [2:0] pin_sync_q;
   logic pin_level_q;
   logic timer_inc_q;
   logic wd_inc_q;
   logic boot_q;
   logic bus_take;
   logic opt_write;
   logic pin_change;
   logic pin_rise;
   logic pin_fall;
   logic pin_event;
   logic src_event;
   logic to_watchdog;
   logic [2:0] rate_field;
   logic [3:0] presc_exp;
   logic presc_event;
   logic presc_tick;
   logic [7:0] presc_count;

   // ------------------------------------------------------------
   // Avalon-MM slave
   // ------------------------------------------------------------

   // A request is taken on the edge where waitrequest is already low
   assign bus_take = (avs_read || avs_write) && !wait_q;
   assign opt_write = bus_take && avs_write && (avs_address == timer_option_pkg::OPTION_ADDR) && avs_byteenable[0];

   // Fixed one-cycle wait: simpler than zero-wait and keeps read data registered
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q <= 1'b1;
      end else if (!wait_q) begin
         wait_q <= 1'b1;
      end else if (avs_read || avs_write) begin
         wait_q <= 1'b0;
      end
   end

   // Read data captured as waitrequest drops; unmapped addresses read zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read && wait_q) begin
         case (avs_address)
            timer_option_pkg::OPTION_ADDR: rdata_q <= {24'h00_0000, option_q};
            timer_option_pkg::STATUS_ADDR: rdata_q <= {24'h00_0000, presc_count};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // Option register: every bit writable, all ones at reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         option_q <= timer_option_pkg::OPTION_RESET;
      end else if (opt_write) begin
         option_q <= avs_writedata[7:0];
      end
   end

   // ------------------------------------------------------------
   // Count pin synchroniser and edge select
   // ------------------------------------------------------------

   // Three stages; a change is accepted only once stages two and three agree
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_sync_q <= timer_option_pkg::SYNC_RESET;
         pin_level_q <= 1'b0;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], timer_count_pin};
         if (pin_sync_q[1] == pin_sync_q[2]) begin
            pin_level_q <= pin_sync_q[2];
         end
      end
   end

   assign pin_change = (pin_sync_q[1] == pin_sync_q[2]) && (pin_sync_q[2] != pin_level_q);
   assign pin_rise = pin_change && pin_sync_q[2];
   assign pin_fall = pin_change && !pin_sync_q[2];
   assign pin_event = option_q[timer_option_pkg::SRC_EDGE_BIT] ? pin_fall : pin_rise;
   assign src_event = option_q[timer_option_pkg::CLK_SRC_BIT] ? pin_event : instr_cycle_tick;

   // ------------------------------------------------------------
   // Prescaler assignment and rate
   // ------------------------------------------------------------

   assign to_watchdog = option_q[timer_option_pkg::ASSIGN_BIT];
   assign rate_field = option_q[timer_option_pkg::RATE_MSB:timer_option_pkg::RATE_LSB];
   // Timer side adds one to the exponent; watchdog side uses the field as is
   assign presc_exp = to_watchdog ? {1'b0, rate_field} : {1'b0, rate_field} + 4'h1;
   assign presc_event = to_watchdog ? watchdog_osc_tick : src_event;

   // Any option write restarts the count so a stale tick never lands on the new path
   prescale_divider u_divider (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .event_in(presc_event),
      .clear(opt_write),
      .rate_exp(presc_exp),
      .tick_q(presc_tick),
      .count_q(presc_count)
   );

   // Route divided or undivided events to the timer and the watchdog
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_inc_q <= 1'b0;
         wd_inc_q <= 1'b0;
      end else begin
         timer_inc_q <= to_watchdog ? src_event : presc_tick;
         wd_inc_q <= to_watchdog ? presc_tick : watchdog_osc_tick;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign timer_increment = timer_inc_q;
   assign watchdog_increment = wd_inc_q;
   assign port_b_a_pullup_disable = option_q[timer_option_pkg::PULLUP_DIS_BIT];
   assign ext_irq_edge_select = option_q[timer_option_pkg::IRQ_EDGE_BIT];

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------

   // Marks the first cycle after reset release
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_q <= 1'b1;
      end else begin
         boot_q <= 1'b0;
      end
   end

   sequence opt_write_s;
      opt_write ##1 1'b1;
   endsequence

   sequence rise_undivided_s;
      option_q[timer_option_pkg::CLK_SRC_BIT] && !option_q[timer_option_pkg::SRC_EDGE_BIT] && to_watchdog && pin_rise;
   endsequence

   sequence fall_undivided_s;
      option_q[timer_option_pkg::CLK_SRC_BIT] && option_q[timer_option_pkg::SRC_EDGE_BIT] && to_watchdog && pin_fall;
   endsequence

   rising_edge_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rise_undivided_s |=> timer_inc_q)
      else $error("rising pin edge did not advance timer");

   falling_edge_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      fall_undivided_s |=> timer_inc_q)
      else $error("falling pin edge did not advance timer");

   wrong_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (option_q[timer_option_pkg::CLK_SRC_BIT] && to_watchdog && !option_q[timer_option_pkg::SRC_EDGE_BIT]
       && pin_fall) |=> !timer_inc_q)
      else $error("timer advanced on the unselected pin edge");

   prescaler_path_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      presc_tick |=> ($past(to_watchdog) ? wd_inc_q : timer_inc_q) == $past(presc_tick))
      else $error("prescaler tick reached the wrong path");

   watchdog_direct_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !to_watchdog |=> wd_inc_q == $past(watchdog_osc_tick))
      else $error("watchdog not fed directly while prescaler serves timer");

   timer_rate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!to_watchdog && presc_tick && $stable(option_q))
      |-> (presc_count & timer_option_pkg::rate_mask({1'b0, rate_field} + 4'h1)) == 8'h00)
      else $error("timer prescale tick off its 2^(n+1) boundary");

   watchdog_rate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (to_watchdog && presc_tick && $stable(option_q))
      |-> (presc_count & timer_option_pkg::rate_mask({1'b0, rate_field})) == 8'h00)
      else $error("watchdog prescale tick off its 2^n boundary");

   undivided_timer_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      to_watchdog |=> timer_inc_q == $past(src_event))
      else $error("timer divided while prescaler serves watchdog");

   reset_value_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      boot_q |-> option_q == timer_option_pkg::OPTION_RESET)
      else $error("option register not all ones after reset");

   option_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      opt_write_s |-> option_q == $past(avs_writedata[7:0]))
      else $error("option write not stored");

endmodule : timer_option_config

`default_nettype wire

// >>> test/pin_source.sv
// Behavioural clock source that drives the timer count pin in bursts
`timescale 1ns/1ps
`default_nettype none

module pin_source (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [7:0] toggles,
   input wire logic [3:0] half,
   output logic pin_q,
   output logic busy
);
   logic [7:0] left_q;
   logic [3:0] cnt_q;

   // Pin stands still between bursts; each level is held for half cycles
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_q <= 1'h0;
         left_q <= 8'h00;
         cnt_q <= 4'h0;
      end else if (start) begin
         left_q <= toggles;
         cnt_q <= half;
      end else if (left_q != 8'h00) begin
         cnt_q <= (cnt_q == 4'h1) ? half : cnt_q - 4'h1;
         if (cnt_q == 4'h1) begin
            pin_q <= ~pin_q;
            left_q <= left_q - 8'h01;
         end
      end
   end

   assign busy = (left_q != 8'h00);
endmodule : pin_source
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the timer option register and its count paths
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
   logic [11:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd, v;
   logic [3:0] avs_byteenable, x;
   logic timer_count_pin, instr_cycle_tick, watchdog_osc_tick, timer_increment, watchdog_increment;
   logic port_b_a_pullup_disable, ext_irq_edge_select, src_start, src_busy, lvl;
   logic [7:0] src_toggles;
   logic [3:0] src_half;
   logic [1:0] tk;
   int bad_count, total_checks, tcnt, wcnt, seed, ni, nw, t;
   localparam logic [11:0] OPT = timer_option_pkg::OPTION_ADDR;

   timer_option_config dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .timer_count_pin(timer_count_pin), .instr_cycle_tick(instr_cycle_tick),
      .watchdog_osc_tick(watchdog_osc_tick), .timer_increment(timer_increment),
      .watchdog_increment(watchdog_increment), .port_b_a_pullup_disable(port_b_a_pullup_disable),
      .ext_irq_edge_select(ext_irq_edge_select));
   pin_source src_u (.sys_clk(sys_clk), .rst_n(rst_n), .start(src_start), .toggles(src_toggles),
      .half(src_half), .pin_q(timer_count_pin), .busy(src_busy));

   // ------------------------------------------------------------
   // Clock, pulse counters and watchdog
   // ------------------------------------------------------------
   initial begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end

   // Sampled mid-cycle so one-cycle pulses are seen exactly once
   always @(negedge sys_clk) begin
      if (timer_increment === 1'h1) tcnt++;
      if (watchdog_increment === 1'h1) wcnt++;
   end

   initial begin
      #(20000 * 50);
      bad_count++;
      print_verdict();
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic print_verdict;
      if (bad_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Request held until the rising edge that samples waitrequest low; read data taken at that edge
   task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] be);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_byteenable <= be;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge sys_clk);
      // Only the bench watchdog ends a wait that never completes
      while (avs_waitrequest !== 1'h0) begin
         @(posedge sys_clk);
      end
      rd = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask : bus

   // Edges of the chosen polarity in a burst that starts from level l
   function automatic int pin_exp(input logic l, input int tg, input logic fall);
      return (l == fall) ? (tg + 1) / 2 : tg / 2;
   endfunction : pin_exp

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      seed = 32'h0000bf12;
      {avs_read, avs_write, instr_cycle_tick, watchdog_osc_tick, src_start} = 5'h00;
      avs_address = 12'h000;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hf;
      src_toggles = 8'h00;
      src_half = 4'h3;
      rst_n = 1'h0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'h1;
      chk("wait idle", 32'h00000001, {31'h0, avs_waitrequest});
      bus(1'h0, OPT, 8'h00, 4'hf);
      chk("option reset", 32'h000000ff, rd);
      chk("side bits", 32'h00000003, {30'h0, port_b_a_pullup_disable, ext_irq_edge_select});
      repeat (4) begin
         v = $random(seed);
         bus(1'h1, OPT, v[7:0], 4'hf);
         bus(1'h1, OPT, ~v[7:0], 4'he);
         bus(1'h1, 12'h300, ~v[7:0], 4'hf);
         bus(1'h0, OPT, 8'h00, 4'hf);
         chk("option rw", {24'h000000, v[7:0]}, rd);
         chk("side bits", {30'h0, v[7:6]}, {30'h0, port_b_a_pullup_disable, ext_irq_edge_select});
      end
      bus(1'h0, 12'h300, 8'h00, 4'hf);
      chk("unmapped read", 32'h00000000, rd);
      // Internal source, every rate on both sides of the shared prescaler
      for (int a = 0; a < 2; a++) begin
         for (int r = 0; r < 8; r++) begin
            bus(1'h1, OPT, {3'h0, 1'h0, 1'(a), 3'(r)}, 4'hf);
            tcnt = 0;
            wcnt = 0;
            ni = 0;
            nw = 0;
            repeat (400) begin
               @(posedge sys_clk);
               tk = 2'($random(seed));
               instr_cycle_tick <= tk[0];
               watchdog_osc_tick <= tk[1];
               ni += tk[0];
               nw += tk[1];
            end
            @(posedge sys_clk);
            instr_cycle_tick <= 1'h0;
            watchdog_osc_tick <= 1'h0;
            repeat (6) @(posedge sys_clk);
            chk("timer count", a ? ni : ni >> (r + 1), tcnt);
            chk("watchdog count", a ? nw >> r : nw, wcnt);
            // The shared counter saw only the events of the path it served
            bus(1'h0, timer_option_pkg::STATUS_ADDR, 8'h00, 4'hf);
            chk("prescale count", 32'((a ? nw : ni) % 256), rd);
         end
      end
      // Pin source, both edges, prescaler on either side
      for (int k = 0; k < 4; k++) begin
         bus(1'h1, OPT, {2'h0, 1'h1, 1'(k), 1'(k >> 1), 3'h0}, 4'hf);
         lvl = timer_count_pin;
         tcnt = 0;
         x = 4'($random(seed));
         t = 5 + x;
         src_toggles <= 8'(t);
         src_half <= 4'h3 + {2'h0, x[1:0]};
         src_start <= 1'h1;
         @(posedge sys_clk);
         src_start <= 1'h0;
         @(negedge sys_clk);
         while (src_busy !== 1'h0) begin
            @(negedge sys_clk);
         end
         repeat (8) @(posedge sys_clk);
         chk("pin count", pin_exp(lvl, t, 1'(k)) >> (k > 1 ? 0 : 1), tcnt);
      end
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
